// [pkg/rsdp_map.svh]
// Notes on behaviour
// [RQ1] Read starts only once has-word flag high.
// [RQ2] Read strobe one cycle; data caught at fall.
// [RQ3] Write starts only once can-accept flag high.
// [RQ4] Write strobe one cycle, data driven meanwhile.
// [RQ5] Peripheral latches write data at strobe fall.
// [RQ6] Keep driving data one cycle after strobe.
// [RQ7] Drive data lines only while enable is set.
// [RQ8] Strobes and drive enable reset to zero.
// [RQ9] Read one word first, then write back.
// [RQ10] Four data lines; idle between transactions.
`ifndef RSDP_MAP_SVH
`define RSDP_MAP_SVH
`define RSDP_DATA_W 4
`define RSDP_SYNC_W 3
`define RSDP_STROBE_RST 1'b0
`define RSDP_DRIVE_RST 1'b0
`define RSDP_WORD_RST 4'h0
`endif

// [pkg/rsdp_pkg.sv]
`default_nettype none
`include "rsdp_map.svh"
package rsdp_pkg;
	typedef enum logic [2:0] {
		RSDP_IDLE,
		RSDP_WAIT_RD,
		RSDP_READ,
		RSDP_WAIT_WR,
		RSDP_WRITE,
		RSDP_HOLD
	} rsdp_state_t;

	typedef logic [`RSDP_DATA_W-1:0] rsdp_word_t;

	typedef struct packed {
		logic [`RSDP_SYNC_W-1:0] stage;
		logic                    level;
	} rsdp_sync_regs_t;

	typedef struct packed {
		rsdp_state_t state;
		logic        rd_strobe;
		logic        wr_strobe;
		logic        drive_en;
		rsdp_word_t  out_word;
		rsdp_word_t  in_word;
		logic        done;
	} rsdp_regs_t;
endpackage : rsdp_pkg
`default_nettype wire

// [rtl/rsdp_sync.sv]
`default_nettype none
`include "rsdp_map.svh"
// ****************************************
// Pin synchroniser
// ****************************************
// A change is accepted only when the second and third stages agree.
module rsdp_sync (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Pin and result
	input  wire logic pin_in,
	output var  logic level_out
);
	rsdp_pkg::rsdp_sync_regs_t s_r;
	rsdp_pkg::rsdp_sync_regs_t s_nxt;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.stage = {s_r.stage[1:0], pin_in};
		if (s_r.stage[1] == s_r.stage[2]) begin
			s_nxt.level = s_r.stage[2];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_out = s_r.level;
endmodule : rsdp_sync
`default_nettype wire

// [rtl/rsdp_port.sv]
`default_nettype none
`include "rsdp_map.svh"
// ****************************************
// Ready-strobe peripheral port
// ****************************************
// A start pulse runs one read from the peripheral followed by one write of
// the read word plus one. The strobes are registered so the pins never glitch.
// Only one transaction is in flight; a start while busy is dropped unnoticed.
module rsdp_port (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst,
	// User side
	input  wire logic                    start,
	output logic                         busy,
	output logic                         done,
	output logic [`RSDP_DATA_W-1:0]      read_word,
	// Peripheral side
	input  wire logic                    peripheral_has_word,
	input  wire logic                    peripheral_can_accept,
	output logic                         read_strobe,
	output logic                         write_strobe,
	input  wire logic [`RSDP_DATA_W-1:0] shared_data_lines_in,
	output logic [`RSDP_DATA_W-1:0]      shared_data_lines_out,
	output logic [`RSDP_DATA_W-1:0]      shared_data_lines_oe
);
	rsdp_pkg::rsdp_regs_t r_r;
	rsdp_pkg::rsdp_regs_t r_nxt;
	logic                 has_word_s;
	logic                 can_accept_s;

	// ****************************************
	// Flag synchronisers
	// ****************************************
	// Both ready flags come from the peripheral's own timing, so each passes a
	// synchroniser; the price is about four cycles of latency per flag.
	rsdp_sync u_sync_rd (
		.mclk      (mclk),
		.rst       (rst),
		.pin_in    (peripheral_has_word),
		.level_out (has_word_s)
	);

	rsdp_sync u_sync_wr (
		.mclk      (mclk),
		.rst       (rst),
		.pin_in    (peripheral_can_accept),
		.level_out (can_accept_s)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// The written word is the read word plus one, wrapping at the top.
	function automatic rsdp_pkg::rsdp_word_t next_word(input rsdp_pkg::rsdp_word_t w);
		return w + `RSDP_DATA_W'(1);
	endfunction : next_word

	// Quiet pins mean no strobe raised and the bus released.
	function automatic logic pins_quiet(input logic rd, input logic wr, input logic drive);
		return !rd && !wr && !drive;
	endfunction : pins_quiet

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		r_nxt      = r_r;
		r_nxt.done = 1'b0;
		case (r_r.state)
			rsdp_pkg::RSDP_IDLE: begin
				// Start is looked at only here, so a start while busy is dropped.
				if (start) begin
					r_nxt.state = rsdp_pkg::RSDP_WAIT_RD; // see [RQ9]
				end
			end
			rsdp_pkg::RSDP_WAIT_RD: begin
				if (has_word_s) begin
					r_nxt.rd_strobe = 1'b1; // see [RQ1]
					r_nxt.state     = rsdp_pkg::RSDP_READ;
				end
			end
			rsdp_pkg::RSDP_READ: begin
				// The peripheral holds the lines steady while the read strobe is high,
				// so the word is taken straight from the pins as the strobe falls.
				r_nxt.rd_strobe = 1'b0; // see [RQ2]
				r_nxt.in_word   = shared_data_lines_in; // see [RQ2]
				r_nxt.out_word  = next_word(shared_data_lines_in);
				r_nxt.state     = rsdp_pkg::RSDP_WAIT_WR; // see [RQ9]
			end
			rsdp_pkg::RSDP_WAIT_WR: begin
				// The bus stayed released through the read, so drive and strobe rise together.
				if (can_accept_s) begin
					r_nxt.wr_strobe = 1'b1; // see [RQ3]
					r_nxt.drive_en  = 1'b1; // see [RQ4]
					r_nxt.state     = rsdp_pkg::RSDP_WRITE;
				end
			end
			rsdp_pkg::RSDP_WRITE: begin
				r_nxt.wr_strobe = 1'b0; // see [RQ4]
				r_nxt.state     = rsdp_pkg::RSDP_HOLD; // see [RQ6]
			end
			rsdp_pkg::RSDP_HOLD: begin
				// The word has stood across the strobe's falling edge; release the bus now.
				r_nxt.drive_en = 1'b0; // see [RQ10]
				r_nxt.done     = 1'b1;
				r_nxt.state    = rsdp_pkg::RSDP_IDLE;
			end
			default: begin
				r_nxt.state = rsdp_pkg::RSDP_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r_r.state     <= rsdp_pkg::RSDP_IDLE;
			r_r.rd_strobe <= `RSDP_STROBE_RST; // see [RQ8]
			r_r.wr_strobe <= `RSDP_STROBE_RST; // see [RQ8]
			r_r.drive_en  <= `RSDP_DRIVE_RST; // see [RQ8]
			r_r.out_word  <= `RSDP_WORD_RST;
			r_r.in_word   <= `RSDP_WORD_RST;
			r_r.done      <= 1'b0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The enable is copied to every lane so the pad drivers switch together.
	assign busy                  = (r_r.state != rsdp_pkg::RSDP_IDLE);
	assign done                  = r_r.done;
	assign read_word             = r_r.in_word;
	assign read_strobe           = r_r.rd_strobe;
	assign write_strobe          = r_r.wr_strobe;
	assign shared_data_lines_out = r_r.out_word;
	assign shared_data_lines_oe  = {`RSDP_DATA_W{r_r.drive_en}}; // see [RQ7]

	// ****************************************
	// Checks
	// ****************************************
	// The checks watch the port's pins together with the synchronised flags and the state register.
	a_read_needs_flag: assert property (@(posedge mclk) disable iff (rst) // see [RQ1]
		$rose(read_strobe) |-> $past(has_word_s))
		else $error("Read strobe raised without has-word flag.");

	a_read_one_cycle: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
		$rose(read_strobe) |=> !read_strobe)
		else $error("Read strobe not exactly one cycle.");

	a_read_capture: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
		$fell(read_strobe) |-> read_word == $past(shared_data_lines_in))
		else $error("Read word not taken at strobe fall.");

	a_write_needs_flag: assert property (@(posedge mclk) disable iff (rst) // see [RQ3]
		$rose(write_strobe) |-> $past(can_accept_s))
		else $error("Write strobe raised without can-accept flag.");

	a_write_drives: assert property (@(posedge mclk) disable iff (rst) // see [RQ4]
		$rose(write_strobe) |-> shared_data_lines_oe[0] ##1 !write_strobe)
		else $error("Write strobe without bus drive or too long.");

	a_write_hold: assert property (@(posedge mclk) disable iff (rst) // see [RQ6]
		$fell(write_strobe) |-> shared_data_lines_oe[0] ##1 !shared_data_lines_oe[0])
		else $error("Bus drive not held exactly one cycle past strobe.");

	a_drive_only_write: assert property (@(posedge mclk) disable iff (rst) // see [RQ7]
		shared_data_lines_oe[0] |-> (r_r.state == rsdp_pkg::RSDP_WRITE || r_r.state == rsdp_pkg::RSDP_HOLD))
		else $error("Bus driven outside a write.");

	a_reset_quiet: assert property (@(posedge mclk) // see [RQ8]
		rst |-> !read_strobe && !write_strobe && !shared_data_lines_oe[0])
		else $error("Strobe or drive active in reset.");

	a_read_before_write: assert property (@(posedge mclk) disable iff (rst) // see [RQ9]
		$rose(read_strobe) |-> !write_strobe ##1 r_r.state == rsdp_pkg::RSDP_WAIT_WR)
		else $error("Write phase does not follow read.");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (rst) // see [RQ10]
		done |-> !busy && !read_strobe && !write_strobe && !shared_data_lines_oe[0])
		else $error("Port not idle after transaction.");

	a_strobes_apart: assert property (@(posedge mclk) disable iff (rst) // see [RQ9]
		!(read_strobe && write_strobe))
		else $error("Read and write strobes high together.");

	a_no_drive_read: assert property (@(posedge mclk) disable iff (rst) // see [RQ7]
		read_strobe |-> !shared_data_lines_oe[0])
		else $error("Bus driven during a read.");

	a_read_waits_flag: assert property (@(posedge mclk) disable iff (rst) // see [RQ1]
		(r_r.state == rsdp_pkg::RSDP_WAIT_RD && !has_word_s) |=> !read_strobe)
		else $error("Read strobe raised while has-word flag low.");

	a_write_waits_flag: assert property (@(posedge mclk) disable iff (rst) // see [RQ3]
		(r_r.state == rsdp_pkg::RSDP_WAIT_WR && !can_accept_s) |=> !write_strobe)
		else $error("Write strobe raised while can-accept flag low.");

	a_out_word_stable: assert property (@(posedge mclk) disable iff (rst) // see [RQ6]
		(shared_data_lines_oe[0] && $past(shared_data_lines_oe[0])) |-> $stable(shared_data_lines_out))
		else $error("Driven word changed while bus driven.");

	a_drive_two_cycles: assert property (@(posedge mclk) disable iff (rst) // see [RQ6]
		$rose(shared_data_lines_oe[0]) |-> write_strobe ##1 (shared_data_lines_oe[0] && !write_strobe)
			##1 !shared_data_lines_oe[0])
		else $error("Bus drive not strobe cycle plus one.");

	a_write_word_next: assert property (@(posedge mclk) disable iff (rst) // see [RQ4]
		$rose(write_strobe) |-> shared_data_lines_out == next_word(read_word))
		else $error("Written word is not read word plus one.");

	a_read_word_holds: assert property (@(posedge mclk) disable iff (rst) // see [RQ2]
		!$fell(read_strobe) |-> $stable(read_word))
		else $error("Read word changed away from strobe fall.");

	a_idle_released: assert property (@(posedge mclk) disable iff (rst) // see [RQ10]
		(r_r.state == rsdp_pkg::RSDP_IDLE) |-> pins_quiet(read_strobe, write_strobe, shared_data_lines_oe[0]))
		else $error("Strobe or drive active while idle.");

	a_done_one_pulse: assert property (@(posedge mclk) disable iff (rst) // see [RQ10]
		done |=> !done)
		else $error("Done pulse longer than one cycle.");

	a_oe_falls_done: assert property (@(posedge mclk) disable iff (rst) // see [RQ10]
		$fell(shared_data_lines_oe[0]) |-> done)
		else $error("Bus released without ending the transaction.");

	a_busy_after_start: assert property (@(posedge mclk) disable iff (rst) // see [RQ9]
		(!busy && start) |=> busy)
		else $error("Start in idle did not begin a transaction.");
endmodule : rsdp_port
`default_nettype wire

// [bench/rsdp_peer.sv]
`default_nettype none
// ****
// Peripheral model
// ****
module rsdp_peer (
	// Clock and strobes
	input  wire logic                 mclk,
	input  wire logic                 read_strobe,
	input  wire logic                 write_strobe,
	// Bus
	input  wire rsdp_pkg::rsdp_word_t dev_out,
	input  wire rsdp_pkg::rsdp_word_t dev_oe,
	output rsdp_pkg::rsdp_word_t      level,
	// Test control
	input  wire rsdp_pkg::rsdp_word_t word,
	output rsdp_pkg::rsdp_word_t      got
);
	timeunit 1ns;
	timeprecision 1ns;
	rsdp_pkg::rsdp_word_t last_r = 4'h0;
	// A released bus flips every cycle outside the read strobe, so a missed capture cannot pass by luck.
	assign level = (dev_oe == 4'hf) ? dev_out : (read_strobe ? word : ~last_r);
	always @(posedge mclk) last_r <= level;
	always @(negedge write_strobe) got <= level;
endmodule : rsdp_peer
`default_nettype wire

// [bench/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 mclk, rst, start, has_w, can_a;
	logic                 busy, done, rd_s, wr_s;
	rsdp_pkg::rsdp_word_t rword, bus_out, bus_oe, level, word, got;
	int                   fails, comparisons, cycles;
	rsdp_port rsdp_port_i (.mclk(mclk), .rst(rst), .start(start), .busy(busy), .done(done), .read_word(rword),
		.peripheral_has_word(has_w), .peripheral_can_accept(can_a), .read_strobe(rd_s), .write_strobe(wr_s),
		.shared_data_lines_in(level), .shared_data_lines_out(bus_out), .shared_data_lines_oe(bus_oe));
	rsdp_peer rsdp_peer_i (.mclk(mclk), .read_strobe(rd_s), .write_strobe(wr_s), .dev_out(bus_out),
		.dev_oe(bus_oe), .level(level), .word(word), .got(got));
	// ****
	// Helpers
	// ****
	task automatic check(input logic [7:0] act, input logic [7:0] exp);
		comparisons++;
		if (act !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, act, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		check({rd_s, wr_s, busy, done, bus_oe}, 8'h00);
	endtask : t_reset
	// Flags are held low for gap cycles to prove that the port really waits.
	task automatic t_xfer(input rsdp_pkg::rsdp_word_t w, input int gap);
		int n;
		word = w;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		repeat (gap) begin
			cyc(1);
			check({rd_s, wr_s, busy, 5'h00}, 8'h20);
		end
		has_w = 1'b1;
		n = 0;
		while (rd_s !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		check({7'h00, rd_s}, 8'h01);
		cyc(1);
		has_w = 1'b0;
		check({7'h00, rd_s}, 8'h00);
		check({4'h0, rword}, {4'h0, w});
		repeat (gap) begin
			cyc(1);
			check({rd_s, wr_s, bus_oe, 2'h0}, 8'h00);
		end
		can_a = 1'b1;
		n = 0;
		while (wr_s !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		check({3'h0, wr_s, bus_oe}, 8'h1f);
		cyc(1);
		can_a = 1'b0;
		check({3'h0, wr_s, bus_oe}, 8'h0f);
		cyc(1);
		check({1'b0, busy, done, wr_s, bus_oe}, 8'h20);
		check({4'h0, got}, {4'h0, w + 4'h1});
		cyc(1);
	endtask : t_xfer
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 2000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		rst = 1'b1;
		start = 1'b0;
		has_w = 1'b0;
		can_a = 1'b0;
		word = 4'h0;
		cyc(8);
		rst = 1'b0;
		t_reset();
		t_xfer(4'h3, 5);
		t_xfer(4'hf, 9);
		t_xfer(4'h0, 6);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
